// File: hw/vglc_pkg.sv
// constants and types for the video gain and luma/chroma processor
package vglc_pkg;
  // ------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_GAIN = 8'h04;
  localparam logic [7:0] ADR_PIC  = 8'h08;
  localparam logic [7:0] ADR_STAT = 8'h0C;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int C_MODE  = 0;
  localparam int C_FRZ   = 2;
  localparam int C_TRAP  = 3;
  localparam int C_YLPF  = 4;
  localparam int C_YCORE = 5;
  localparam int C_PEAK  = 6;
  localparam int C_PKSEL = 7;
  localparam int C_CBW   = 8;
  localparam int C_CCORE = 9;
  localparam int C_CLINK = 10;
  localparam int C_PAL   = 11;
  localparam int C_LIE   = 12;
  localparam int P_BRI   = 0;
  localparam int P_CON   = 8;
  localparam int P_SAT   = 16;
  localparam int P_HUE   = 24;
  localparam int S_PRES  = 10;
  localparam int S_LOST  = 11;
  // ------------------------------------------------------------
  // reset values and levels
  // ------------------------------------------------------------
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [9:0]  GAIN_RST = 10'h080;
  localparam logic [9:0]  GAIN_ONE = 10'h080;
  localparam logic [9:0]  GAIN_MAX = 10'h3FF;
  localparam logic [31:0] PIC_RST  = 32'h0080_8000;
  localparam logic [7:0]  TRIM_RST = 8'h80;
  localparam logic [9:0]  BLANK_TGT = 10'h0F0;
  localparam logic [7:0]  CODE_LO  = 8'h01;
  localparam logic [7:0]  CODE_HI  = 8'hFE;
  localparam logic [7:0]  Y_OFS    = 8'h10;
  localparam logic [7:0]  C_MID    = 8'h80;
  localparam int BP_LOG  = 4;
  localparam logic [8:0] THIRD_K = 9'h0AB;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int LOSS_US = 256;
  localparam int LOSS_CYC = LOSS_US * CLK_MHZ;
  typedef enum logic [1:0] {GM_AUTO, GM_FREEZE, GM_UNITY, GM_FIXED} vglc_gmode_t;
endpackage

// File: hw/vglc_top.sv
// video gain, rate conversion and luma/chroma output processing
`timescale 1ns/100ps
// Summary of operation
// - four gain modes: auto, freeze, unity, fixed
// - lowpass, average back porch over three lines
// - auto gain drives blank to target
// - freeze captures current auto gain value
// - unity gain, offset keeps blank on target
// - programmed gain, offset keeps blank on target
// - clamp makes sync tip code zero
// - anti-alias filter on 2x samples
// - input resampler to virtual 4fsc rate
// - detect signal, flag loss to software
// - output resampler, aligned by line sync
// - colour difference scaled to 16..240
// - luma minus black, kept signed
// - luma scaled black 0, white 219
// - optional chroma trap at subcarrier
// - luma lowpass and coring options
// - peaking at 2.6MHz or subcarrier
// - brightness offset, contrast multiply
// - add 16, map 0/255 to 1/254
// - chroma lowpass two bandwidths, coring
// - saturation multiply, optional contrast link
// - hue offsets regenerated subcarrier phase unless pal
// - chroma map 0/255 to 1/254
module vglc_top
  import vglc_pkg::*;
#(
  parameter int LOSS_CYCLES = LOSS_CYC,
  parameter logic [15:0] IRC_STEP = 16'h87C1,
  parameter logic [15:0] ORC_STEP = 16'hF15E,
  parameter logic [9:0]  Y_BLACK  = 10'h0F0,
  parameter logic [8:0]  Y_SCALE  = 9'h046,
  parameter logic [8:0]  C_SCALE  = 9'h0E0,
  parameter logic [7:0]  CORE_T   = 8'h04
)(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // adc side and line timing
  input  wire logic [9:0]  adc_data,
  input  wire logic        adc_valid,
  input  wire logic        sync_tip,
  input  wire logic        back_porch,
  input  wire logic        line_start,
  output logic      [7:0]  clamp_trim,
  // towards comb filter
  output logic      [9:0]  irc_data,
  output logic             irc_valid,
  output logic      [7:0]  hue_phase,
  // from demodulator
  input  wire logic [9:0]  dm_luma,
  input  wire logic [9:0]  dm_u,
  input  wire logic [9:0]  dm_v,
  input  wire logic        dm_valid,
  // pixel output and status
  output logic      [7:0]  y_out,
  output logic      [7:0]  cb_out,
  output logic      [7:0]  cr_out,
  output logic             pix_valid,
  output logic             sig_present,
  output logic             sig_lost
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] clip8(input logic signed [13:0] x);
    if (x < $signed({6'h00, CODE_LO})) clip8 = CODE_LO;
    else if (x > $signed({6'h00, CODE_HI})) clip8 = CODE_HI;
    else clip8 = x[7:0];
  endfunction
  function automatic logic signed [11:0] core(input logic signed [11:0] x, input logic en);
    logic signed [11:0] t;
    t = $signed({4'h0, CORE_T});
    core = (en && x < t && x > -t) ? 12'sh000 : x;
  endfunction
  function automatic logic signed [11:0] interp(input logic signed [11:0] a,
                                                input logic signed [11:0] b,
                                                input logic [7:0] w);
    logic signed [21:0] s;
    s = a * $signed({2'b00, w}) + b * $signed(10'h100 - {2'b00, w});
    interp = s[19:8];
  endfunction

  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  logic [31:0] ctrl_r, pic_r, sh_ctrl_r, sh_pic_r, rd_mux, wb_dat_r;
  logic [9:0]  gain_r, sh_gain_r, agc_r, frz_r;
  logic        wb_ack_r, lost_r, present_r, frz_pulse;
  wire         wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_r;
  wire         wb_wr  = wb_hit & wb_we_i & wb_sel_i[0];
  assign frz_pulse = wb_wr && wb_adr_i == ADR_CTRL && wb_dat_i[C_FRZ];
  wire         lost_clr = wb_wr && wb_adr_i == ADR_STAT && wb_dat_i[S_LOST];
  assign rd_mux = wb_adr_i == ADR_CTRL ? ctrl_r :
                  wb_adr_i == ADR_GAIN ? {22'h0, gain_r} :
                  wb_adr_i == ADR_PIC  ? pic_r :
                  wb_adr_i == ADR_STAT ? {20'h0, lost_r, present_r, agc_r} : 32'h0;
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
    begin
      ctrl_r   <= CTRL_RST;
      gain_r   <= GAIN_RST;
      pic_r    <= PIC_RST;
      wb_ack_r <= 1'b0;
      wb_dat_r <= 32'h0;
    end
    else
    begin
      wb_ack_r <= wb_hit;
      wb_dat_r <= wb_hit ? rd_mux : 32'h0;
      if (wb_wr && wb_adr_i == ADR_CTRL) ctrl_r <= wb_dat_i & ~(32'h1 << C_FRZ);
      if (wb_wr && wb_adr_i == ADR_GAIN) gain_r <= wb_dat_i[9:0];
      if (wb_wr && wb_adr_i == ADR_PIC)  pic_r  <= wb_dat_i;
    end
  assign wb_ack_o = wb_ack_r;
  assign wb_dat_o = wb_dat_r;

  // settings except the C_LIE loss flag enable take effect only at a line boundary
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
    begin
      sh_ctrl_r <= CTRL_RST;
      sh_gain_r <= GAIN_RST;
      sh_pic_r  <= PIC_RST;
    end
    else if (line_start)
    begin
      sh_ctrl_r <= ctrl_r;
      sh_gain_r <= gain_r;
      sh_pic_r  <= pic_r;
    end

  // ------------------------------------------------------------
  // gain and offset stage
  // ------------------------------------------------------------
  vglc_gmode_t gm;
  assign gm = vglc_gmode_t'(sh_ctrl_r[C_MODE +: 2]);
  logic [9:0]  geff, g_r, g_d, g_dd, lin0, lin1, lin2, meas;
  logic signed [10:0] off_r;
  logic [13:0] bp_sum;
  logic        line_d, hist_ok;
  logic [1:0]  hist_n;
  assign geff = gm == GM_AUTO   ? agc_r :
                gm == GM_FREEZE ? frz_r :
                gm == GM_UNITY  ? GAIN_ONE : sh_gain_r;
  wire [19:0]  prod = adc_data * geff;
  wire signed [13:0] gsum = $signed({1'b0, prod[19:7]}) + {{3{off_r[10]}}, off_r};
  wire [9:0]   gclip = gsum < 0 ? 10'h000 : gsum > 14'sd1023 ? 10'h3FF : gsum[9:0];
  wire [10:0]  glp = {1'b0, g_r} + {1'b0, g_d};
  wire [11:0]  l3 = {2'b00, lin0} + {2'b00, lin1} + {2'b00, lin2};
  wire [20:0]  l3k = l3 * THIRD_K;
  assign meas = l3k[18:9];
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
    begin
      g_r <= 10'h0; g_d <= 10'h0; g_dd <= 10'h0;
      bp_sum <= 14'h0; lin0 <= 10'h0; lin1 <= 10'h0; lin2 <= 10'h0;
      hist_n <= 2'd0; line_d <= 1'b0;
      agc_r <= GAIN_RST; frz_r <= GAIN_RST; off_r <= 11'sh000;
    end
    else
    begin
      line_d <= line_start;
      if (adc_valid)
      begin
        g_r <= gclip; g_d <= g_r; g_dd <= g_d;
      end
      if (line_start)
      begin
        lin0 <= bp_sum[BP_LOG +: 10]; lin1 <= lin0; lin2 <= lin1;
        bp_sum <= 14'h0;
        if (hist_n != 2'd3) hist_n <= hist_n + 2'd1;
      end
      else if (adc_valid && back_porch)
        bp_sum <= bp_sum + {4'h0, glp[10:1]};
      if (frz_pulse) frz_r <= agc_r;
      if (line_d && hist_ok)
      begin
        if (gm == GM_AUTO)
        begin
          off_r <= 11'sh000;
          if (meas < BLANK_TGT && agc_r != GAIN_MAX) agc_r <= agc_r + 10'h1;
          else if (meas > BLANK_TGT && agc_r != 10'h1) agc_r <= agc_r - 10'h1;
        end
        else if (gm != GM_FREEZE || off_r != 11'sh000)
        begin
          if (meas < BLANK_TGT && off_r != 11'sh3FF) off_r <= off_r + 11'sh001;
          else if (meas > BLANK_TGT && off_r != -11'sh3FF) off_r <= off_r - 11'sh001;
        end
      end
    end
  assign hist_ok = hist_n == 2'd3;

  // clamp trim: hunt so the sync tip digitises to code zero
  logic [7:0] trim_r;
  always_ff @(posedge ref_clk or posedge reset)
    if (reset) trim_r <= TRIM_RST;
    else if (sync_tip && adc_valid)
    begin
      if (adc_data != 10'h0 && trim_r != 8'h00) trim_r <= trim_r - 8'h01;
      else if (adc_data == 10'h0 && trim_r != 8'hFF) trim_r <= trim_r + 8'h01;
    end
  assign clamp_trim = trim_r;

  // ------------------------------------------------------------
  // anti-alias filter and input rate converter
  // ------------------------------------------------------------
  logic [9:0]  aa_r, aa_d, irc_r;
  logic [15:0] irc_acc;
  logic        irc_v_r;
  wire [11:0]  aa_s = {2'b00, g_r} + {1'b0, g_d, 1'b0} + {2'b00, g_dd};
  wire [16:0]  irc_nxt = {1'b0, irc_acc} + {1'b0, IRC_STEP};
  wire signed [11:0] irc_i = interp($signed({2'b00, aa_d}), $signed({2'b00, aa_r}),
                                    irc_nxt[15:8]);
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
    begin
      aa_r <= 10'h0; aa_d <= 10'h0; irc_r <= 10'h0;
      irc_acc <= 16'h0; irc_v_r <= 1'b0;
    end
    else
    begin
      irc_v_r <= adc_valid & irc_nxt[16];
      if (adc_valid)
      begin
        aa_r <= aa_s[11:2];
        aa_d <= aa_r;
        irc_acc <= irc_nxt[15:0];
        if (irc_nxt[16]) irc_r <= irc_i[9:0];
      end
    end
  assign irc_data  = irc_r;
  assign irc_valid = irc_v_r;

  // ------------------------------------------------------------
  // luma filters at 4fsc
  // ------------------------------------------------------------
  logic signed [11:0] yt [0:6];
  logic signed [11:0] ct [0:1][0:3];
  logic v1, v2, v3;
  wire [7:0] con = sh_pic_r[P_CON +: 8];
  wire [7:0] sat = sh_pic_r[P_SAT +: 8];
  genvar gi, ci;
  generate
    for (gi = 0; gi < 7; gi++)
    begin : g_ytap
      always_ff @(posedge ref_clk or posedge reset)
        if (reset) yt[gi] <= 12'sh000;
        else if (dm_valid)
          yt[gi] <= gi == 0 ? $signed({2'b00, dm_luma}) - $signed({2'b00, Y_BLACK})
                            : yt[gi == 0 ? 0 : gi - 1];
    end
  endgenerate
  wire signed [13:0] y_trap = (yt[1] + 14'sd2 * yt[3] + yt[5]) >>> 2;
  wire signed [13:0] y_lpf  = (yt[2] + 14'sd2 * yt[3] + yt[4]) >>> 2;
  wire signed [13:0] y_hp   = sh_ctrl_r[C_PKSEL] ? 14'sd2 * yt[3] - yt[1] - yt[5]
                                                 : 14'sd2 * yt[3] - yt[0] - yt[6];
  wire signed [11:0] y_base = sh_ctrl_r[C_TRAP] ? y_trap[11:0] :
                              sh_ctrl_r[C_YLPF] ? y_lpf[11:0] : yt[3];
  wire signed [11:0] y_pk = sh_ctrl_r[C_PEAK] ? core(y_hp[13:2], sh_ctrl_r[C_YCORE])
                                              : 12'sh000;
  wire signed [20:0] y_sc = (y_base + y_pk) * $signed({1'b0, Y_SCALE});
  wire signed [11:0] y_cr = core(y_sc[19:8], sh_ctrl_r[C_YCORE]);
  wire signed [20:0] y_ct = y_cr * $signed({1'b0, con});
  wire signed [11:0] y_adj = y_ct[18:7] + {{4{sh_pic_r[P_BRI + 7]}}, sh_pic_r[P_BRI +: 8]};
  wire [15:0]  sc16 = sat * con;
  wire [8:0]   sat_eff = sh_ctrl_r[C_CLINK] ? sc16[15:7] : {1'b0, sat};

  // ------------------------------------------------------------
  // chroma filters, coring and saturation
  // ------------------------------------------------------------
  logic signed [11:0] c_adj [0:1];
  logic signed [11:0] a_r [0:2];
  generate
    for (ci = 0; ci < 2; ci++)
    begin : g_chr
      wire [9:0] cin = ci == 0 ? dm_u : dm_v;
      wire signed [13:0] c_w = (ct[ci][0] + 14'sd2 * ct[ci][1] + ct[ci][2]) >>> 2;
      wire signed [13:0] c_n = (ct[ci][0] + ct[ci][1] + ct[ci][2] + ct[ci][3]) >>> 2;
      wire signed [11:0] c_f = core(sh_ctrl_r[C_CBW] ? c_w[11:0] : c_n[11:0],
                                    sh_ctrl_r[C_CCORE]);
      wire signed [21:0] c_s = c_f * $signed({1'b0, sat_eff});
      assign c_adj[ci] = c_s[18:7];
      always_ff @(posedge ref_clk or posedge reset)
        if (reset)
        begin
          ct[ci][0] <= 12'sh000; ct[ci][1] <= 12'sh000;
          ct[ci][2] <= 12'sh000; ct[ci][3] <= 12'sh000;
        end
        else if (dm_valid)
        begin
          ct[ci][0] <= $signed({2'b00, cin}) - $signed({2'b00, C_MID, 2'b00});
          ct[ci][1] <= ct[ci][0]; ct[ci][2] <= ct[ci][1]; ct[ci][3] <= ct[ci][2];
        end
    end
  endgenerate

  // ------------------------------------------------------------
  // output rate converter and final clipping
  // ------------------------------------------------------------
  logic signed [11:0] a_d [0:2];
  logic signed [11:0] o_r [0:2];
  logic [15:0] orc_acc;
  logic [7:0]  y_r, cb_r, cr_r, hue_r;
  logic        pv_r;
  wire [16:0]  orc_nxt = {1'b0, orc_acc} + {1'b0, ORC_STEP};
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_orc
      always_ff @(posedge ref_clk or posedge reset)
        if (reset)
        begin
          a_r[gi] <= 12'sh000; a_d[gi] <= 12'sh000; o_r[gi] <= 12'sh000;
        end
        else
        begin
          if (v1)
          begin
            a_r[gi] <= gi == 0 ? y_adj : c_adj[gi == 0 ? 0 : gi - 1];
            a_d[gi] <= a_r[gi];
          end
          if (v2 && orc_nxt[16]) o_r[gi] <= interp(a_d[gi], a_r[gi], orc_nxt[15:8]);
        end
    end
  endgenerate
  wire signed [20:0] cb_s = o_r[1] * $signed({1'b0, C_SCALE});
  wire signed [20:0] cr_s = o_r[2] * $signed({1'b0, C_SCALE});
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
    begin
      v1 <= 1'b0; v2 <= 1'b0; v3 <= 1'b0; pv_r <= 1'b0; orc_acc <= 16'h0;
      y_r <= Y_OFS; cb_r <= C_MID; cr_r <= C_MID; hue_r <= 8'h00;
    end
    else
    begin
      v1 <= dm_valid;
      v2 <= v1;
      v3 <= v2 & orc_nxt[16];
      pv_r <= v3;
      hue_r <= sh_ctrl_r[C_PAL] ? 8'h00 : sh_pic_r[P_HUE +: 8];
      if (line_start) orc_acc <= 16'h0;
      else if (v2) orc_acc <= orc_nxt[15:0];
      if (v3)
      begin
        y_r  <= clip8({{2{o_r[0][11]}}, o_r[0]} + {6'h00, Y_OFS});
        cb_r <= clip8({cb_s[20], cb_s[20:8]} + {6'h00, C_MID});
        cr_r <= clip8({cr_s[20], cr_s[20:8]} + {6'h00, C_MID});
      end
    end
  assign y_out = y_r;
  assign cb_out = cb_r;
  assign cr_out = cr_r;
  assign pix_valid = pv_r;
  assign hue_phase = hue_r;

  // ------------------------------------------------------------
  // input signal detection
  // ------------------------------------------------------------
  logic [31:0] loss_cnt;
  logic        lost_out_r;
  wire         pres_nxt = line_start ? 1'b1 :
                          loss_cnt == 32'(LOSS_CYCLES - 1) ? 1'b0 : present_r;
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
    begin
      loss_cnt <= 32'h0; present_r <= 1'b0; lost_r <= 1'b0; lost_out_r <= 1'b0;
    end
    else
    begin
      loss_cnt <= line_start || !present_r ? 32'h0 : loss_cnt + 32'h1;
      present_r <= pres_nxt;
      if (present_r && !pres_nxt) lost_r <= 1'b1;
      else if (lost_clr) lost_r <= 1'b0;
      lost_out_r <= lost_r & ctrl_r[C_LIE];
    end
  assign sig_present = present_r;
  assign sig_lost = lost_out_r;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_r; endsequence
  sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
  property p_wb_ack; @(posedge ref_clk) disable iff (reset) s_req |=> s_ans; endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("ack not single cycle");
  property p_unity; @(posedge ref_clk) disable iff (reset)
    gm == GM_UNITY |-> geff == GAIN_ONE && prod[19:7] == {3'b000, adc_data}; endproperty
  a_unity: assert property (p_unity) else $error("unity gain not one");
  property p_freeze; @(posedge ref_clk) disable iff (reset)
    frz_pulse |=> frz_r == $past(agc_r); endproperty
  a_freeze: assert property (p_freeze) else $error("freeze missed gain");
  property p_agc_up; @(posedge ref_clk) disable iff (reset)
    line_d && hist_ok && gm == GM_AUTO && meas < BLANK_TGT && agc_r != GAIN_MAX
    |=> agc_r == $past(agc_r) + 10'h1; endproperty
  a_agc_up: assert property (p_agc_up) else $error("auto gain not raised");
  property p_off; @(posedge ref_clk) disable iff (reset)
    line_d && hist_ok && (gm == GM_UNITY || gm == GM_FIXED) && meas < BLANK_TGT
    && off_r != 11'sh3FF |=> off_r == $past(off_r) + 11'sh001; endproperty
  a_off: assert property (p_off) else $error("blank offset not raised");
  property p_y_rng; @(posedge ref_clk) disable iff (reset)
    pix_valid |-> y_out >= 8'h01 && y_out <= 8'hFE; endproperty
  a_y_rng: assert property (p_y_rng) else $error("luma code out of range");
  property p_c_rng; @(posedge ref_clk) disable iff (reset)
    pix_valid |-> cb_out != 8'h00 && cb_out != 8'hFF && cr_out != 8'h00 && cr_out != 8'hFF;
  endproperty
  a_c_rng: assert property (p_c_rng) else $error("chroma code out of range");
  property p_shadow; @(posedge ref_clk) disable iff (reset)
    !line_start |=> $stable(sh_pic_r) && $stable(sh_ctrl_r); endproperty
  a_shadow: assert property (p_shadow) else $error("settings changed mid line");
  property p_lost; @(posedge ref_clk) disable iff (reset)
    $fell(sig_present) |-> lost_r; endproperty
  a_lost: assert property (p_lost) else $error("loss not flagged");
  property p_hue; @(posedge ref_clk) disable iff (reset)
    sh_ctrl_r[C_PAL] |=> hue_phase == 8'h00; endproperty
  a_hue: assert property (p_hue) else $error("hue applied in pal");
endmodule

// File: bench/vglc_src_model.sv
// adc front end model: line timing, 2x samples, clamp-dependent sync tip
`timescale 1ns/100ps
module vglc_src_model
  import vglc_pkg::*;
(
  // clock and control
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       run,
  input  wire logic [7:0] clamp_trim,
  // adc side
  output logic      [9:0] adc_data,
  output logic            adc_valid,
  output logic            sync_tip,
  output logic            back_porch,
  output logic            line_start
);
  logic [5:0] pos_r;
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      pos_r      <= 6'h00;
      adc_data   <= 10'h000;
      adc_valid  <= 1'b0;
      sync_tip   <= 1'b0;
      back_porch <= 1'b0;
      line_start <= 1'b0;
    end
    else
    begin
      pos_r      <= run ? pos_r + 6'h01 : 6'h00;
      adc_valid  <= run & pos_r[0];
      line_start <= run & (pos_r == 6'h3F);
      sync_tip   <= run & (pos_r < 6'h08);
      back_porch <= run & (pos_r >= 6'h0C) & (pos_r < 6'h1C);
      // stopped source shows a code that toggles every cycle, not the last code
      if (!run)
        adc_data <= ~adc_data;
      else if (pos_r < 6'h08)
        adc_data <= (clamp_trim > 8'h70) ? {2'b00, clamp_trim - 8'h70} : 10'h000;
      else if (pos_r < 6'h1C)
        adc_data <= 10'h0C0;
      else
        adc_data <= 10'h200;
    end
  end
endmodule

// File: bench/tb_vglc_top.sv
// self-checking bench for the video gain and luma/chroma processor
`timescale 1ns/100ps
module tb_vglc_top
  import vglc_pkg::*;
;
  logic        ref_clk  = 1'b0;
  logic        reset    = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [9:0]  dm_luma  = 10'h000;
  logic [9:0]  dm_u     = 10'h200;
  logic [9:0]  dm_v     = 10'h200;
  logic        dm_valid = 1'b0;
  logic        run      = 1'b0;
  logic [31:0] wb_dat_o, rd, g1;
  logic [9:0]  adc_data, irc_data;
  logic        wb_ack_o, adc_valid, sync_tip, back_porch, line_start, irc_valid;
  logic        pix_valid, sig_present, sig_lost;
  logic [7:0]  clamp_trim, hue_phase, y_out, cb_out, cr_out;
  logic [29:0] rin [3] = '{{10'h3FF, 10'h3FF, 10'h000}, {10'h000, 10'h000, 10'h3FF},
                           {10'h3FF, 10'h200, 10'h200}};
  logic [23:0] rout [3] = '{24'hE6FE01, 24'h0101FE, 24'hE68080};
  int          err_count = 0;
  int          n_pix = 0;
  int          n_compared = 0;
  int          n;

  vglc_top #(.LOSS_CYCLES(200)) vglc_top_i (
    .ref_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .adc_data, .adc_valid, .sync_tip, .back_porch, .line_start,
    .clamp_trim, .irc_data, .irc_valid, .hue_phase, .dm_luma, .dm_u, .dm_v, .dm_valid,
    .y_out, .cb_out, .cr_out, .pix_valid, .sig_present, .sig_lost);
  vglc_src_model vglc_src_model_i (
    .ref_clk, .reset, .run, .clamp_trim, .adc_data, .adc_valid, .sync_tip, .back_porch,
    .line_start);

  always #5 ref_clk = ~ref_clk;

  // pixel strobes seen since the start
  always @(posedge ref_clk) n_pix <= n_pix + int'(pix_valid);

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic complete_run();
    if (err_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic give_up();
    err_count++;
    complete_run();
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 20);
    if (k >= 20)
      give_up();
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wait_line();
    int k;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (line_start !== 1'b1 && k < 200);
    if (k >= 200)
      give_up();
  endtask

  task automatic feed(input logic [29:0] s);
    repeat (24)
    begin
      @(posedge ref_clk);
      {dm_luma, dm_u, dm_v} <= s;
      dm_valid <= 1'b1;
      @(posedge ref_clk);
      dm_valid <= 1'b0;
      repeat (2) @(posedge ref_clk);
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    #1;
    check({clamp_trim, y_out, cb_out, cr_out}, 32'h8010_8080);
    check({hue_phase, pix_valid, sig_present, sig_lost}, 32'h0);
    wb(1'b0, ADR_GAIN, 4'hF, 32'h0);
    check(rd, {22'h0, GAIN_RST});
    wb(1'b0, ADR_PIC, 4'hF, 32'h0);
    check(rd, PIC_RST);
    wb(1'b1, 8'h10, 4'hF, 32'hFFFF_FFFF);
    wb(1'b0, 8'h10, 4'hF, 32'h0);
    check(rd, 32'h0);
    wb(1'b1, ADR_GAIN, 4'hE, 32'h0000_01A5);
    wb(1'b0, ADR_GAIN, 4'hF, 32'h0);
    check(rd, {22'h0, GAIN_RST});
    wb(1'b1, ADR_GAIN, 4'hF, 32'h0000_01A5);
    wb(1'b0, ADR_GAIN, 4'hF, 32'h0);
    check(rd, 32'h0000_01A5);
    for (int m = 3; m >= 0; m--)
    begin
      wb(1'b1, ADR_CTRL, 4'hF, m);
      wb(1'b0, ADR_CTRL, 4'hF, 32'h0);
      check(rd, m);
    end
    n = n_pix;
    run <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      feed(rin[i]);
      repeat (6) @(posedge ref_clk);
      check({y_out, cb_out, cr_out}, rout[i]);
    end
    check(n_pix - n >= 58 && n_pix - n <= 72, 32'h1);
    wait_line();
    wb(1'b1, ADR_PIC, 4'hF, 32'h3580_8000);
    check(hue_phase, 32'h0);
    wait_line();
    repeat (2) @(posedge ref_clk);
    check(hue_phase, 32'h35);
    wb(1'b1, ADR_CTRL, 4'hF, 32'h0000_0800);
    wait_line();
    repeat (2) @(posedge ref_clk);
    check(hue_phase, 32'h0);
    repeat (30) wait_line();
    check(clamp_trim[7:1], 32'h38);
    wb(1'b0, ADR_STAT, 4'hF, 32'h0);
    check(rd[9:0] > GAIN_ONE, 32'h1);
    wb(1'b1, ADR_CTRL, 4'hF, 32'h0000_0005);
    wb(1'b0, ADR_STAT, 4'hF, 32'h0);
    g1 = rd;
    repeat (4) wait_line();
    wb(1'b0, ADR_STAT, 4'hF, 32'h0);
    check(rd[9:0], g1[9:0]);
    wb(1'b1, ADR_CTRL, 4'hF, 32'h0000_0002);
    repeat (8) wait_line();
    check(irc_data > 10'h200 && irc_data < 10'h210, 32'h1);
    wb(1'b1, ADR_CTRL, 4'hF, 32'h0000_0003);
    repeat (6) wait_line();
    check(irc_data, 10'h3FF);
    n = 0;
    repeat (512)
    begin
      @(posedge ref_clk);
      n += irc_valid;
    end
    check(n >= 135 && n <= 136, 32'h1);
    check(sig_present, 32'h1);
    wb(1'b1, ADR_CTRL, 4'hF, 32'h0000_1000);
    run <= 1'b0;
    n = 0;
    while (sig_lost !== 1'b1 && n < 600)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 600)
      give_up();
    wb(1'b0, ADR_STAT, 4'hF, 32'h0);
    check(rd[11:10], 32'h2);
    wb(1'b1, ADR_STAT, 4'hF, 32'h0000_0800);
    repeat (2) @(posedge ref_clk);
    check(sig_lost, 32'h0);
    run <= 1'b1;
    repeat (4) wait_line();
    wb(1'b1, ADR_CTRL, 4'hF, 32'h0);
    run <= 1'b0;
    repeat (600) @(posedge ref_clk);
    check(sig_lost, 32'h0);
    wb(1'b0, ADR_STAT, 4'hF, 32'h0);
    check(rd[11], 32'h1);
    complete_run();
  end
endmodule
